/* common/mrs_defines.svh */
// constants of the message receiver: lengths, kind codes, initial values
// assumes byte-wide delivery of one message at a time by the transport
`ifndef MRS_DEFINES_SVH
`define MRS_DEFINES_SVH
`define MRS_HDR_LEN 16'h0014
`define MRS_SUBHDR_LEN 16'h0004
`define MRS_LAST_SUBHDR_IDX 16'h0003
`define MRS_CAP_N 16'h001c
`define MRS_CAP_BITS 224
`define MRS_MAGIC 32'h5254_5053
`define MRS_CUR_REV 16'h0204
`define MRS_MAKER_NONE 16'h0000
`define MRS_KNOWN_MAKER 16'h0001
`define MRS_PREFIX_NONE 96'h0000_0000_0000_0000_0000_0000
`define MRS_ADDR_INVALID 128'h0000_0000_0000_0000_0000_0000_0000_0000
`define MRS_PORT_INVALID 32'h0000_0000
`define MRS_TIME_INVALID 64'hffff_ffff_ffff_ffff
`define MRS_PAD_SUB 8'h01
`define MRS_ACK_NAK_SUB 8'h06
`define MRS_LIVENESS_SUB 8'h07
`define MRS_GAP_SUB 8'h08
`define MRS_TIME_INFO_SUB 8'h09
`define MRS_SRC_INFO_SUB 8'h0c
`define MRS_DST_INFO_SUB 8'h0e
`define MRS_REPLY_INFO_SUB 8'h0f
`define MRS_FRAGMENT_NAK_SUB 8'h12
`define MRS_LIVENESS_FRAGMENT_SUB 8'h13
`define MRS_DATA_SUB 8'h15
`define MRS_DATA_FRAGMENT_SUB 8'h16
`define MRS_VENDOR_LO 8'h80
`define MRS_MIN_SRC 16'h0014
`define MRS_MIN_DST 16'h000c
`define MRS_MIN_TIME 16'h0008
`define MRS_MIN_REPLY 16'h0004
`define MRS_FLAG_ORDER 0
`define MRS_FLAG_TINVAL 1
`define MRS_MASK_DATA 8'h1f
`define MRS_MASK_FRAG 8'h0f
`define MRS_MASK_ACK 8'h03
`define MRS_MASK_BASE 8'h01
`define MRS_OFF_REV 4
`define MRS_OFF_MAKER 6
`define MRS_OFF_PREFIX 8
`define MRS_OFF_LKIND 4
`define MRS_OFF_LPORT 8
`define MRS_OFF_LADDR 12
`endif

/* common/mrs_pkg.sv */
// types shared by the message receiver and its buffer
// assumes the constants of mrs_defines.svh
package mrs_pkg;
	typedef logic [7:0] mrs_byte_t;
	typedef struct packed {
		logic [31:0] kind;
		logic [31:0] port;
		logic [127:0] addr;
	} mrs_locator_s;
	typedef struct packed {
		logic [15:0] sender_proto_rev;
		logic [15:0] sender_maker_code;
		logic [95:0] sender_unique_prefix;
		logic [95:0] target_unique_prefix;
		mrs_locator_s single_reply_addr_list;
		mrs_locator_s group_reply_addr_list;
		logic time_present_flag;
		logic [63:0] timestamp;
	} mrs_ctx_s;
	typedef struct packed {
		mrs_byte_t data;
		logic first;
		logic last;
		logic [15:0] msg_total_len;
		logic [31:0] transport_kind;
		logic [127:0] src_addr;
		logic src_addr_ok;
	} mrs_word_s;
	typedef struct packed {
		mrs_byte_t sub_kind_code;
		mrs_byte_t flags;
		logic [15:0] body_len;
		logic to_end;
	} mrs_desc_s;
	typedef enum logic [2:0] {MRS_IDLE, MRS_MHDR, MRS_SHDR, MRS_BODY, MRS_DRAIN} mrs_state_e;
endpackage

/* core/mrs_receiver.sv */
// message receiver: byte FIFO plus the submessage walker and its context
// assumes the transport hands one message at a time, byte wide, with meta on every beat
//
// Contract
// R1: each new message wipes the old context and loads initial values first.
// R2: initial rev current, maker and source prefix none, target local, no time.
// R3: unicast reply locator: transport kind, source address or invalid, invalid port.
// R4: multicast reply locator: transport kind, invalid address, invalid port.
// R5: fewer bytes left than a submessage header abandons the rest.
// R6: length field finds the next submessage; an oversize length abandons the rest.
// R7: kinds outside the defined set are skipped, walking continues.
// R8: vendor range kinds from an unrecognised maker are skipped.
// R9: flag bits not defined for a kind are ignored.
// R10: a valid length always steers to the next submessage, known kinds too.
// R11: a known submessage failing its checks abandons it and the rest.
// R12: only the header and the four info kinds change the context.
// R13: endpoint kinds are delivered with the current context.
// R14: a context update governs every later submessage of the message.
// R15: flag bit 0 picks byte order; set means little endian.
// R16: zero length means the submessage runs to the message end.
// R17: length excludes the four header bytes.
// R18: header is kind, flags, two length bytes; abandoning raises an event.
// R19: transport gives bounded messages with length, transport kind and source.
`timescale 1ns/1ps
`include "mrs_defines.svh"

module mrs_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic reset_n_in,
	// fill side
	input wire logic [W-1:0] wr_data_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	// drain side
	output logic [W-1:0] rd_data_out,
	output logic rd_valid_out,
	input wire logic rd_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pull;
	logic [AW:0] cnt_d;

	assign push = wr_valid_in && wr_ready_out;
	assign pull = rd_valid_out && rd_ready_in;
	assign rd_data_out = mem_q[rp_q];
	assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pull};

	always_ff @(posedge clock_in)
	begin
		if (push)
		begin
			mem_q[wp_q] <= wr_data_in;
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			wr_ready_out <= 1'b1;
			rd_valid_out <= 1'b0;
		end
		else
		begin
			wp_q <= push ? AW'(wp_q + 1'b1) : wp_q;
			rp_q <= pull ? AW'(rp_q + 1'b1) : rp_q;
			cnt_q <= cnt_d;
			wr_ready_out <= (cnt_d != (AW+1)'(DEPTH));
			rd_valid_out <= (cnt_d != '0);
		end
	end
endmodule

module mrs_receiver (
	// clock and reset
	input wire logic clock_in,
	input wire logic reset_n_in,
	// received datagram bytes with transport meta
	input wire mrs_pkg::mrs_word_s in_word_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	// local participant
	input wire logic [95:0] local_prefix_in,
	// submessage body bytes toward the endpoint
	output mrs_pkg::mrs_byte_t body_byte_out,
	output logic body_valid_out,
	input wire logic body_ready_in,
	// delivery, context and events
	output mrs_pkg::mrs_desc_s deliver_desc_out,
	output logic deliver_out,
	output mrs_pkg::mrs_ctx_s ctx_out,
	output logic abandon_out,
	output logic msg_done_out
);
	mrs_pkg::mrs_word_s w;
	logic f_valid;
	logic pop;
	mrs_pkg::mrs_state_e state_q;
	mrs_pkg::mrs_state_e st_d;
	logic [15:0] idx_q;
	logic [15:0] rem_q;
	logic [15:0] rem_n;
	logic [15:0] body_q;
	logic [15:0] blen;
	logic [15:0] hlen;
	mrs_pkg::mrs_byte_t kind_q;
	mrs_pkg::mrs_byte_t flags_q;
	mrs_pkg::mrs_byte_t b2_q;
	logic to_end_q;
	logic [`MRS_CAP_BITS-1:0] cap_q;
	logic [`MRS_CAP_BITS-1:0] cap_w;
	logic init;
	logic hdr_ok;
	logic sub_end;
	logic len_go;
	logic abandon_d;
	logic fwd;

	function automatic logic [15:0] sub_len(input logic le, input logic [7:0] b2,
		input logic [7:0] b3);
		sub_len = le ? {b3, b2} : {b2, b3};
	endfunction

	function automatic logic is_endpoint(input logic [7:0] k);
		case (k)
			`MRS_DATA_SUB, `MRS_DATA_FRAGMENT_SUB, `MRS_LIVENESS_SUB, `MRS_ACK_NAK_SUB,
			`MRS_GAP_SUB, `MRS_LIVENESS_FRAGMENT_SUB, `MRS_FRAGMENT_NAK_SUB: is_endpoint = 1'b1;
			default: is_endpoint = 1'b0;
		endcase
	endfunction

	// least body length of each info kind; zero means no check
	function automatic logic [15:0] min_len(input logic [7:0] k, input logic [7:0] f);
		case (k)
			`MRS_SRC_INFO_SUB: min_len = `MRS_MIN_SRC;
			`MRS_DST_INFO_SUB: min_len = `MRS_MIN_DST;
			`MRS_REPLY_INFO_SUB: min_len = `MRS_MIN_REPLY;
			`MRS_TIME_INFO_SUB: min_len = f[`MRS_FLAG_TINVAL] ? 16'h0000 : `MRS_MIN_TIME;
			default: min_len = 16'h0000;
		endcase
	endfunction

	function automatic logic [7:0] flag_mask(input logic [7:0] k);
		case (k)
			`MRS_DATA_SUB: flag_mask = `MRS_MASK_DATA;
			`MRS_DATA_FRAGMENT_SUB: flag_mask = `MRS_MASK_FRAG;
			`MRS_ACK_NAK_SUB, `MRS_LIVENESS_SUB: flag_mask = `MRS_MASK_ACK;
			default: flag_mask = `MRS_MASK_BASE;
		endcase
	endfunction

	// 16 bytes of the capture window starting at a byte offset
	function automatic logic [127:0] cap_at(input logic [`MRS_CAP_BITS-1:0] c, input int off);
		cap_at = c[`MRS_CAP_BITS-1-8*off -: 128];
	endfunction

	mrs_fifo #(
		.W($bits(mrs_pkg::mrs_word_s)),
		.DEPTH(16)
	) u_fifo (
		.clock_in(clock_in),
		.reset_n_in(reset_n_in),
		.wr_data_in(in_word_in),
		.wr_valid_in(in_valid_in),
		.wr_ready_out(in_ready_out),
		.rd_data_out(w),
		.rd_valid_out(f_valid),
		.rd_ready_in(pop)
	);

	// an unread body byte stalls the walker, so back-pressure reaches the fifo and transport
	assign pop = f_valid && (!body_valid_out || body_ready_in);
	assign rem_n = (rem_q == 16'h0000) ? 16'h0000 : rem_q - 16'h0001;
	assign hlen = sub_len(flags_q[`MRS_FLAG_ORDER], b2_q, w.data); // R15
	assign blen = (hlen == 16'h0000) ? rem_n : hlen;
	assign fwd = is_endpoint(kind_q)
		|| (kind_q >= `MRS_VENDOR_LO && ctx_out.sender_maker_code == `MRS_KNOWN_MAKER);

	always_comb
	begin
		cap_w = cap_q;
		if (pop && state_q != mrs_pkg::MRS_SHDR && state_q != mrs_pkg::MRS_DRAIN
			&& idx_q < `MRS_CAP_N)
		begin
			cap_w[`MRS_CAP_BITS-1-8*idx_q -: 8] = w.data;
		end
	end

	always_comb
	begin
		st_d = state_q;
		init = 1'b0;
		hdr_ok = 1'b0;
		sub_end = 1'b0;
		len_go = 1'b0;
		abandon_d = 1'b0;
		if (pop)
		begin
			case (state_q)
				mrs_pkg::MRS_IDLE:
				begin
					if (w.first)
					begin
						init = 1'b1;
						st_d = mrs_pkg::MRS_MHDR;
						if (w.msg_total_len < `MRS_HDR_LEN)
						begin
							st_d = mrs_pkg::MRS_DRAIN;
							abandon_d = 1'b1;
						end
					end
				end
				mrs_pkg::MRS_MHDR:
				begin
					if (idx_q == `MRS_HDR_LEN - 16'h0001)
					begin
						if (32'(cap_at(cap_w, 0) >> 96) == `MRS_MAGIC)
						begin
							hdr_ok = 1'b1;
							st_d = (rem_n == 16'h0000) ? mrs_pkg::MRS_IDLE : mrs_pkg::MRS_SHDR;
						end
						else
						begin
							st_d = mrs_pkg::MRS_DRAIN;
							abandon_d = 1'b1;
						end
					end
				end
				mrs_pkg::MRS_SHDR:
				begin
					if (idx_q == 16'h0000 && rem_q < `MRS_SUBHDR_LEN) // R5
					begin
						st_d = mrs_pkg::MRS_DRAIN;
						abandon_d = 1'b1;
					end
					else if (idx_q == `MRS_LAST_SUBHDR_IDX)
					begin
						if (hlen > rem_n || blen < min_len(kind_q, flags_q)) // R6 R11
						begin
							st_d = mrs_pkg::MRS_DRAIN;
							abandon_d = 1'b1;
						end
						else if (blen == 16'h0000)
						begin
							sub_end = 1'b1;
							st_d = (rem_n == 16'h0000) ? mrs_pkg::MRS_IDLE : mrs_pkg::MRS_SHDR;
						end
						else
						begin
							len_go = 1'b1;
							st_d = mrs_pkg::MRS_BODY;
						end
					end
				end
				mrs_pkg::MRS_BODY:
				begin
					if (body_q == 16'h0001) // R10
					begin
						sub_end = 1'b1;
						st_d = (rem_n == 16'h0000) ? mrs_pkg::MRS_IDLE : mrs_pkg::MRS_SHDR;
					end
				end
				default:
				begin
				end
			endcase
			// a message cut short by the transport ends the walk here
			if (w.last && st_d != mrs_pkg::MRS_IDLE)
			begin
				abandon_d = abandon_d || (state_q != mrs_pkg::MRS_DRAIN
					&& st_d != mrs_pkg::MRS_DRAIN);
				st_d = mrs_pkg::MRS_IDLE;
			end
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			state_q <= mrs_pkg::MRS_IDLE;
			idx_q <= 16'h0000;
			rem_q <= 16'h0000;
			body_q <= 16'h0000;
		end
		else if (pop)
		begin
			state_q <= st_d;
			rem_q <= init ? w.msg_total_len - 16'h0001 : rem_n;
			if (init)
			begin
				idx_q <= 16'h0001;
			end
			else if (sub_end || st_d != state_q)
			begin
				idx_q <= 16'h0000;
			end
			else
			begin
				idx_q <= idx_q + 16'h0001;
			end
			if (len_go)
			begin
				body_q <= blen; // R16 R17
			end
			else if (state_q == mrs_pkg::MRS_BODY)
			begin
				body_q <= body_q - 16'h0001;
			end
		end
	end

	// submessage header bytes: kind, flags, then two length bytes
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			kind_q <= 8'h00;
			flags_q <= 8'h00;
			b2_q <= 8'h00;
			to_end_q <= 1'b0;
			cap_q <= '0;
		end
		else if (pop)
		begin
			cap_q <= cap_w;
			if (state_q == mrs_pkg::MRS_SHDR)
			begin
				case (idx_q[1:0]) // R18
					2'h0: kind_q <= w.data;
					2'h1: flags_q <= w.data;
					2'h2: b2_q <= w.data;
					default: to_end_q <= (hlen == 16'h0000); // R16
				endcase
			end
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			ctx_out <= '0;
		end
		else if (init) // R1
		begin
			ctx_out.sender_proto_rev <= `MRS_CUR_REV; // R2
			ctx_out.sender_maker_code <= `MRS_MAKER_NONE;
			ctx_out.sender_unique_prefix <= `MRS_PREFIX_NONE;
			ctx_out.target_unique_prefix <= local_prefix_in;
			ctx_out.time_present_flag <= 1'b0;
			ctx_out.timestamp <= `MRS_TIME_INVALID;
			ctx_out.single_reply_addr_list.kind <= w.transport_kind; // R3
			ctx_out.single_reply_addr_list.addr <= w.src_addr_ok ? w.src_addr : `MRS_ADDR_INVALID;
			ctx_out.single_reply_addr_list.port <= `MRS_PORT_INVALID;
			ctx_out.group_reply_addr_list.kind <= w.transport_kind; // R4
			ctx_out.group_reply_addr_list.addr <= `MRS_ADDR_INVALID;
			ctx_out.group_reply_addr_list.port <= `MRS_PORT_INVALID;
		end
		else if (hdr_ok || (sub_end && kind_q == `MRS_SRC_INFO_SUB)) // R12 R14
		begin
			ctx_out.sender_proto_rev <= 16'(cap_at(cap_w, `MRS_OFF_REV) >> 112);
			ctx_out.sender_maker_code <= 16'(cap_at(cap_w, `MRS_OFF_MAKER) >> 112);
			ctx_out.sender_unique_prefix <= 96'(cap_at(cap_w, `MRS_OFF_PREFIX) >> 32);
		end
		else if (sub_end && kind_q == `MRS_DST_INFO_SUB) // R12
		begin
			ctx_out.target_unique_prefix <= 96'(cap_at(cap_w, 0) >> 32);
		end
		else if (sub_end && kind_q == `MRS_TIME_INFO_SUB) // R12
		begin
			ctx_out.time_present_flag <= !flags_q[`MRS_FLAG_TINVAL];
			ctx_out.timestamp <= flags_q[`MRS_FLAG_TINVAL] ? `MRS_TIME_INVALID
				: 64'(cap_at(cap_w, 0) >> 64);
		end
		else if (sub_end && kind_q == `MRS_REPLY_INFO_SUB && body_q >= 16'h0001
			&& 32'(cap_at(cap_w, 0) >> 96) != 32'h0000_0000) // R12
		begin
			// only the first unicast locator is kept; longer lists are not held
			ctx_out.single_reply_addr_list.kind <= 32'(cap_at(cap_w, `MRS_OFF_LKIND) >> 96);
			ctx_out.single_reply_addr_list.port <= 32'(cap_at(cap_w, `MRS_OFF_LPORT) >> 96);
			ctx_out.single_reply_addr_list.addr <= cap_at(cap_w, `MRS_OFF_LADDR);
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			body_byte_out <= 8'h00;
			body_valid_out <= 1'b0;
			deliver_out <= 1'b0;
			deliver_desc_out <= '0;
			abandon_out <= 1'b0;
			msg_done_out <= 1'b0;
		end
		else
		begin
			deliver_out <= sub_end && fwd; // R7 R8 R13
			abandon_out <= abandon_d; // R18
			msg_done_out <= pop && st_d == mrs_pkg::MRS_IDLE && state_q != mrs_pkg::MRS_IDLE;
			if (sub_end)
			begin
				deliver_desc_out.sub_kind_code <= kind_q;
				deliver_desc_out.flags <= flags_q & flag_mask(kind_q); // R9
				deliver_desc_out.body_len <= (state_q == mrs_pkg::MRS_SHDR) ? 16'h0000 : idx_q + 16'h0001;
				deliver_desc_out.to_end <= to_end_q && state_q == mrs_pkg::MRS_BODY;
			end
			if (pop && state_q == mrs_pkg::MRS_BODY && fwd)
			begin
				body_byte_out <= w.data;
				body_valid_out <= 1'b1;
			end
			else if (body_ready_in)
			begin
				body_valid_out <= 1'b0;
			end
		end
	end

	default clocking @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);

	ctx_init_a: assert property (init |=> ctx_out.time_present_flag == 1'b0 // R1
		&& ctx_out.sender_maker_code == `MRS_MAKER_NONE && ctx_out.target_unique_prefix
		== $past(local_prefix_in)) else $error("context not reset at message start");
	rev_init_a: assert property (init |=> ctx_out.sender_proto_rev == `MRS_CUR_REV // R2
		&& ctx_out.timestamp == `MRS_TIME_INVALID) else $error("initial rev or time wrong");
	uni_init_a: assert property (init |=> ctx_out.single_reply_addr_list.addr == // R3
		($past(w.src_addr_ok) ? $past(w.src_addr) : `MRS_ADDR_INVALID)
		&& ctx_out.single_reply_addr_list.port == `MRS_PORT_INVALID)
		else $error("unicast locator initial value wrong");
	grp_init_a: assert property (init |=> ctx_out.group_reply_addr_list.addr == // R4
		`MRS_ADDR_INVALID && ctx_out.group_reply_addr_list.kind == $past(w.transport_kind))
		else $error("multicast locator initial value wrong");
	short_hdr_a: assert property (pop && state_q == mrs_pkg::MRS_SHDR && idx_q == 16'h0000 // R5
		&& rem_q < `MRS_SUBHDR_LEN |=> abandon_out) else $error("short header not abandoned");
	bad_len_a: assert property (pop && state_q == mrs_pkg::MRS_SHDR // R6
		&& idx_q == `MRS_LAST_SUBHDR_IDX && hlen > rem_n |=> abandon_out && !deliver_out)
		else $error("oversize length not abandoned");
	skip_kind_a: assert property (deliver_out |-> is_endpoint(deliver_desc_out.sub_kind_code) // R7 R8
		|| (deliver_desc_out.sub_kind_code >= `MRS_VENDOR_LO
		&& ctx_out.sender_maker_code == `MRS_KNOWN_MAKER)) else $error("skipped kind delivered");
	flag_drop_a: assert property (deliver_out |-> (deliver_desc_out.flags // R9
		& ~flag_mask(deliver_desc_out.sub_kind_code)) == 8'h00) else $error("unknown flags passed");
	len_walk_a: assert property (len_go && hlen != 16'h0000 |=> body_q == $past(hlen) // R10 R17
		##0 state_q == mrs_pkg::MRS_BODY) else $error("length not used to walk");
	to_end_a: assert property (len_go && hlen == 16'h0000 |=> body_q == $past(rem_n)) // R16
		else $error("zero length does not run to end");
	bad_info_a: assert property (pop && state_q == mrs_pkg::MRS_SHDR // R11
		&& idx_q == `MRS_LAST_SUBHDR_IDX && hlen <= rem_n && blen < min_len(kind_q, flags_q)
		|=> abandon_out ##1 state_q != mrs_pkg::MRS_BODY) else $error("invalid info not abandoned");
	ctx_hold_a: assert property (!$past(init) && !$past(hdr_ok) && !$past(sub_end) // R12 R14
		|-> $stable(ctx_out)) else $error("context changed without cause");

	deliver_c: cover property (deliver_out ##[1:40] deliver_out);
	abandon_c: cover property (abandon_out ##[1:40] msg_done_out);
	info_c: cover property (sub_end && kind_q == `MRS_SRC_INFO_SUB ##[1:60] deliver_out);
endmodule

/* tb/mrs_tb_transport.sv */
// transport-side model: hands one queued datagram to the receiver, byte by byte
// assumes the receiver's valid/ready input stream and meta on every beat
`timescale 1ns/1ps

module mrs_tb_transport (
	// clock and reset
	input wire logic clock_in,
	input wire logic reset_n_in,
	// datagram stream toward the receiver
	output mrs_pkg::mrs_word_s word_out,
	output logic valid_out,
	input wire logic ready_in
);
	mrs_pkg::mrs_byte_t q[$];
	logic slow;
	logic hung;

	initial
	begin
		word_out = '0;
		valid_out = 1'b0;
		slow = 1'b0;
		hung = 1'b0;
	end

	// beats are held until ready is seen; in slow mode the data lane shows junk between beats
	task automatic send(input logic [31:0] kind, input logic [127:0] src, input logic ok);
		int n;
		int k;
		n = q.size();
		@(posedge clock_in);
		for (int i = 0; i < n; i++)
		begin
			word_out <= '{data: q[i], first: (i == 0), last: (i == n - 1),
				msg_total_len: 16'(n), transport_kind: kind,
				src_addr: src, src_addr_ok: ok};
			valid_out <= 1'b1;
			k = 0;
			do
			begin
				@(negedge clock_in);
				k++;
			end
			while (ready_in !== 1'b1 && k < 2000);
			if (k >= 2000)
			begin
				hung = 1'b1;
				break;
			end
			@(posedge clock_in);
			if (slow && i < n - 1)
			begin
				valid_out <= 1'b0;
				word_out.data <= ~q[i];
				@(posedge clock_in);
			end
		end
		valid_out <= 1'b0;
		word_out.data <= ~q[n - 1];
		q.delete();
	endtask
endmodule

/* tb/testbench.sv */
// self-checking bench: builds messages, sends them through the transport model,
// and compares deliveries, abandons and context against expectations
`timescale 1ns/1ps
`include "mrs_defines.svh"

module testbench;
	localparam logic [127:0] SRC = 128'h0a0b_0c0d_1111_2222_3333_4444_5555_6666;
	localparam logic [31:0] KIND = 32'h0000_0001;
	localparam logic [95:0] LOCAL = 96'h1234_5678_9abc_def0_0f1e_2d3c;

	logic clock_in;
	logic reset_n_in;
	mrs_pkg::mrs_word_s in_word;
	logic in_valid;
	logic in_ready;
	logic [95:0] local_prefix;
	mrs_pkg::mrs_byte_t body_byte;
	logic body_valid;
	logic body_ready;
	mrs_pkg::mrs_desc_s desc;
	logic deliver;
	mrs_pkg::mrs_ctx_s ctx;
	logic abandon;
	logic msg_done;

	int err_count;
	int n_compared;
	int n_done;
	int n_ab;
	int n_body;
	int exp_body;
	int stall;
	logic saw_full;
	logic [7:0] exp_k[$];
	logic [15:0] exp_l[$];
	logic [1:0] exp_f[$];
	logic [7:0] exp_b[$];
	mrs_pkg::mrs_desc_s got_d[$];
	mrs_pkg::mrs_ctx_s last_ctx;

	mrs_receiver u_dut (
		.clock_in(clock_in), .reset_n_in(reset_n_in),
		.in_word_in(in_word), .in_valid_in(in_valid), .in_ready_out(in_ready),
		.local_prefix_in(local_prefix),
		.body_byte_out(body_byte), .body_valid_out(body_valid), .body_ready_in(body_ready),
		.deliver_desc_out(desc), .deliver_out(deliver), .ctx_out(ctx),
		.abandon_out(abandon), .msg_done_out(msg_done)
	);

	mrs_tb_transport u_xport (
		.clock_in(clock_in), .reset_n_in(reset_n_in),
		.word_out(in_word), .valid_out(in_valid), .ready_in(in_ready)
	);

	always #5 clock_in = ~clock_in;

	// endpoint sink toggles ready, or holds it low while a stall is counted down
	always @(posedge clock_in)
	begin
		body_ready <= (stall == 0) ? ~body_ready : 1'b0;
		if (stall > 0)
			stall <= stall - 1;
	end

	always @(posedge clock_in)
	begin
		if (deliver === 1'b1)
		begin
			got_d.push_back(desc);
			last_ctx = ctx;
		end
		if (abandon === 1'b1)
			n_ab++;
		if (msg_done === 1'b1)
			n_done++;
		if (body_valid === 1'b1 && body_ready === 1'b1)
		begin
			n_body++;
			chk(body_byte, (exp_b.size() > 0) ? exp_b.pop_front() : 16'h0100);
		end
		if (in_ready === 1'b0 && reset_n_in === 1'b1)
			saw_full = 1'b1;
	end

	task automatic chk(input logic [191:0] got, input logic [191:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		if (err_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic put(input logic [7:0] b);
		u_xport.q.push_back(b);
	endtask

	task automatic hdr(input logic [15:0] maker);
		for (int i = 0; i < 4; i++)
			put(8'(`MRS_MAGIC >> (24 - 8 * i)));
		put(8'h02);
		put(8'h04);
		put(maker[15:8]);
		put(maker[7:0]);
		for (int i = 0; i < 12; i++)
			put(8'(8'ha0 + i));
	endtask

	// length bytes follow the byte order selected by flag bit 0
	task automatic sub(input logic [7:0] kind, input logic [7:0] fl, input logic [15:0] len,
		input int nb, input logic dlv);
		put(kind);
		put(fl);
		if (fl[0])
		begin
			put(len[7:0]);
			put(len[15:8]);
		end
		else
		begin
			put(len[15:8]);
			put(len[7:0]);
		end
		for (int i = 0; i < nb; i++)
		begin
			put(8'(i) ^ 8'h5a);
			if (dlv)
				exp_b.push_back(8'(i) ^ 8'h5a);
		end
		if (dlv)
		begin
			exp_k.push_back(kind);
			exp_l.push_back(16'(nb));
			exp_f.push_back({len == 16'h0000, fl[0]});
			exp_body += nb;
		end
	endtask

	task automatic run(input logic ok, input int ab_exp);
		int d0;
		int k;
		d0 = n_done;
		u_xport.send(KIND, SRC, ok);
		k = 0;
		while (n_done == d0 && k < 600)
		begin
			@(negedge clock_in);
			k++;
		end
		if (k >= 600 || u_xport.hung)
		begin
			err_count++;
			print_verdict();
		end
		repeat (4) @(negedge clock_in);
		chk(128'(got_d.size()), 128'(exp_k.size()));
		foreach (exp_k[i])
		begin
			if (i < got_d.size())
			begin
				chk(got_d[i].sub_kind_code, exp_k[i]);
				chk(got_d[i].body_len, exp_l[i]);
				chk({got_d[i].to_end, got_d[i].flags[7], got_d[i].flags[0]},
					{exp_f[i][1], 1'b0, exp_f[i][0]});
			end
		end
		chk(128'(n_ab), 128'(ab_exp));
		chk(128'(n_done - d0), 128'd1);
		chk(128'(n_body), 128'(exp_body));
		exp_k.delete();
		exp_l.delete();
		exp_f.delete();
		exp_b.delete();
		got_d.delete();
		n_ab = 0;
		n_body = 0;
		exp_body = 0;
	endtask

	initial
	begin
		clock_in = 1'b0;
		reset_n_in = 1'b0;
		local_prefix = LOCAL;
		body_ready = 1'b0;
		err_count = 0;
		n_compared = 0;
		n_done = 0;
		n_ab = 0;
		n_body = 0;
		exp_body = 0;
		stall = 0;
		saw_full = 1'b0;
		repeat (3) @(posedge clock_in);
		reset_n_in <= 1'b1;
		@(posedge clock_in);
		// known maker, spaced beats: skips, context update, vendor and tail delivery
		u_xport.slow = 1'b1;
		hdr(`MRS_KNOWN_MAKER);
		sub(8'h30, 8'h00, 16'h0004, 4, 1'b0);
		sub(`MRS_TIME_INFO_SUB, 8'h00, 16'h0008, 8, 1'b0);
		sub(`MRS_DATA_SUB, 8'hff, 16'h0004, 4, 1'b1);
		sub(`MRS_VENDOR_LO, 8'h01, 16'h0004, 4, 1'b1);
		sub(`MRS_GAP_SUB, 8'h00, 16'h0000, 6, 1'b1);
		run(1'b1, 0);
		chk(last_ctx.time_present_flag, 1'b1);
		chk(last_ctx.sender_maker_code, `MRS_KNOWN_MAKER);
		chk(last_ctx.target_unique_prefix, LOCAL);
		chk(last_ctx.single_reply_addr_list, {KIND, `MRS_PORT_INVALID, SRC});
		chk(last_ctx.group_reply_addr_list, {KIND, `MRS_PORT_INVALID, `MRS_ADDR_INVALID});
		// unknown maker, stalled endpoint fills the buffer, every endpoint kind delivered
		u_xport.slow = 1'b0;
		stall = 60;
		hdr(`MRS_MAKER_NONE);
		sub(`MRS_VENDOR_LO, 8'h00, 16'h0004, 4, 1'b0);
		sub(`MRS_DATA_SUB, 8'h01, 16'h0004, 4, 1'b1);
		sub(`MRS_DATA_FRAGMENT_SUB, 8'h01, 16'h0004, 4, 1'b1);
		sub(`MRS_LIVENESS_SUB, 8'h00, 16'h0004, 4, 1'b1);
		sub(`MRS_ACK_NAK_SUB, 8'h01, 16'h0004, 4, 1'b1);
		sub(`MRS_GAP_SUB, 8'h00, 16'h0004, 4, 1'b1);
		sub(`MRS_LIVENESS_FRAGMENT_SUB, 8'h01, 16'h0004, 4, 1'b1);
		sub(`MRS_FRAGMENT_NAK_SUB, 8'h00, 16'h0004, 4, 1'b1);
		run(1'b0, 0);
		chk(saw_full, 1'b1);
		chk(last_ctx.time_present_flag, 1'b0);
		chk(last_ctx.sender_maker_code, `MRS_MAKER_NONE);
		chk(last_ctx.single_reply_addr_list, {KIND, `MRS_PORT_INVALID, `MRS_ADDR_INVALID});
		// source info sets the maker seen by later submessages; oversize length abandons the rest
		hdr(`MRS_KNOWN_MAKER);
		sub(`MRS_SRC_INFO_SUB, 8'h00, 16'h0014, 20, 1'b0);
		sub(`MRS_DATA_SUB, 8'h00, 16'h0004, 4, 1'b1);
		sub(`MRS_DATA_SUB, 8'h00, 16'h0064, 4, 1'b0);
		run(1'b1, 1);
		chk(last_ctx.sender_maker_code, 16'h5c5d);
		// truncated submessage header abandons the rest
		hdr(`MRS_KNOWN_MAKER);
		sub(`MRS_LIVENESS_SUB, 8'h01, 16'h0004, 4, 1'b1);
		put(8'h15);
		put(8'h00);
		run(1'b1, 1);
		// short info body is a known but invalid submessage
		hdr(`MRS_KNOWN_MAKER);
		sub(`MRS_DST_INFO_SUB, 8'h00, 16'h0004, 4, 1'b0);
		sub(`MRS_DATA_SUB, 8'h00, 16'h0004, 4, 1'b0);
		run(1'b1, 1);
		print_verdict();
	end
endmodule
